/* pbsram_consts.svh */
// Purpose: constants of the pipelined burst sram access block
// Assumes: one 10 MHz clock, sys_clk
// Notes:   all figures used by the logic are named here
`ifndef PBSRAM_CONSTS_SVH
`define PBSRAM_CONSTS_SVH

// array geometry: 256K words, four lanes of eight data bits plus parity
`define ADDR_W          18
`define LOW_ADDR_W      2
`define NUM_LANES       4
`define BYTE_W          8
`define LANE_W          9
`define DATA_W          32
`define WORD_W          36
`define DEPTH           262144

// sleep entry and exit, in clock cycles (two clock periods each)
`define CLK_PERIOD_NS   100
`define SLEEP_TIME_NS   200
`define SLEEP_CYC       ((`SLEEP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// asynchronous input bit positions in the synchroniser vector
`define ASYNC_W         3
`define ASYNC_OE        0
`define ASYNC_SLEEP     1
`define ASYNC_ORDER     2

// reset values of the asynchronous inputs: oe off, awake, interleaved
`define ASYNC_RST       3'h5

`define LOW_ONE         2'h1
`define LOW_ZERO        2'h0
`define CNT_ZERO        2'h0
`define CNT_ONE         2'h1

`endif

/* pbsram_pkg.sv */
// Purpose: types shared by the pipelined burst sram access block
// Assumes: pbsram_consts.svh supplies widths
// Notes:   control pins travel together as one packed struct
`include "pbsram_consts.svh"

package pbsram_pkg;

  // synchronous control pins of the sram bus, all sampled at clock rise
  typedef struct packed {
    logic                    proc_addr_strobe_n;
    logic                    ctrl_addr_strobe_n;
    logic                    burst_advance_n;
    logic                    global_write_n;
    logic                    lane_write_enable_n;
    logic [`NUM_LANES-1:0]   lane_select_n;
    logic                    chip_sel_a_n;
    logic                    chip_sel_b;
    logic                    chip_sel_c_n;
  } bus_ctl_s;

  // power state of the array
  typedef enum logic [1:0] {
    st_awake,
    st_entering,
    st_asleep,
    st_leaving
  } sleep_e;

endpackage

/* pipelined_burst_sram_access.sv */
// Purpose: access control of a pipelined burst sram with common data i/o
// Assumes: control pins are synchronous to sys_clk; oe, sleep and burst
//          order arrive asynchronously and are synchronised here
// Notes:   reads show data one clock after the address is taken
//
// Summary of operation
// - Processor strobe low with all chip selects active captures address.
// - First cycle of a processor-strobe access ignores write and advance.
// - Processor-strobe write completes at second clock, global write stores all.
// - With global write high, byte write enable low writes only lanes whose select is low.
// - Strobe-started write with global write stores every lane.
// - Controller strobe alone, selected, with write controls writes in one clock.
// - Processor strobe always starts a read regardless of write controls.
// - Data drivers turn off whenever a write cycle is detected.
// - Two-bit wraparound burst counter loads from the lowest address bits.
// - Burst order: interleaved when order select high, linear when low.
// - Interleaved burst address is start xor step count.
// - Linear burst address is previous value plus one, modulo four.
// - Burst advance low steps the counter, for reads and writes.
// - Sleep tri-states data, keeps contents, two clocks to enter or leave.
// - Access pending at sleep entry is dropped.
// - Without a strobe, advance picks next or current address.
// - Write condition: global write low, or lane enable with a lane low.
// - Output enable is not part of the access and is masked during writes.
// - Reads drive the pins when oe is low, else tri-state.
// - Both strobes low: the processor strobe counts, or the controller strobe when chip select a is high.
// - Read data appears on the pins after the next clock rise.
// - First read clock after deselect keeps outputs tri-stated.
`timescale 1ns/10ps
`include "pbsram_consts.svh"

module pipelined_burst_sram_access
(
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // synchronous address and control
  input  wire logic [`ADDR_W-1:0]    addr,
  input  wire pbsram_pkg::bus_ctl_s  ctl,
  // asynchronous inputs
  input  wire logic                  out_en_n,
  input  wire logic                  sleep_request,
  input  wire logic                  burst_order_sel,
  // data pins, split into input, output and enable (low drives)
  input  wire logic [`DATA_W-1:0]    dq_in,
  output logic      [`DATA_W-1:0]    dq_out,
  output logic      [`DATA_W-1:0]    dq_oe_n,
  // parity pins, one per lane
  input  wire logic [`NUM_LANES-1:0] parity_pins_in,
  output logic      [`NUM_LANES-1:0] parity_pins_out,
  output logic      [`NUM_LANES-1:0] parity_pins_oe_n,
  // status
  output logic                       sleep_active
);

  // asynchronous inputs: three stages, a change counts once two agree
  logic [`ASYNC_W-1:0] async_s1_ff;
  logic [`ASYNC_W-1:0] async_s2_ff;
  logic [`ASYNC_W-1:0] async_s3_ff;
  logic [`ASYNC_W-1:0] async_f_ff;
  logic [`ASYNC_W-1:0] nxt_async_f;

  always_comb
  begin
    nxt_async_f = async_f_ff;
    if (async_s2_ff == async_s3_ff)
    begin
      nxt_async_f = async_s3_ff;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      async_s1_ff <= `ASYNC_RST;
      async_s2_ff <= `ASYNC_RST;
      async_s3_ff <= `ASYNC_RST;
      async_f_ff  <= `ASYNC_RST;
    end
    else
    begin
      async_s1_ff <= {burst_order_sel, sleep_request, out_en_n};
      async_s2_ff <= async_s1_ff;
      async_s3_ff <= async_s2_ff;
      async_f_ff  <= nxt_async_f;
    end
  end

  logic oe_f_n;
  logic sleep_f;
  logic order_interleaved;
  assign oe_f_n            = async_f_ff[`ASYNC_OE];
  assign sleep_f           = async_f_ff[`ASYNC_SLEEP];
  assign order_interleaved = async_f_ff[`ASYNC_ORDER];

  // sleep state: two clocks to enter and two to leave
  pbsram_pkg::sleep_e sleep_ff;
  pbsram_pkg::sleep_e nxt_sleep;
  logic [1:0]         slp_cnt_ff;
  logic [1:0]         nxt_slp_cnt;
  logic               awake;

  always_comb
  begin
    nxt_sleep   = sleep_ff;
    nxt_slp_cnt = `CNT_ZERO;
    case (sleep_ff)
      pbsram_pkg::st_awake:
      begin
        if (sleep_f)
        begin
          nxt_sleep   = pbsram_pkg::st_entering;
          nxt_slp_cnt = `CNT_ONE;
        end
      end
      pbsram_pkg::st_entering:
      begin
        nxt_slp_cnt = slp_cnt_ff + `CNT_ONE;
        if (slp_cnt_ff >= 2'(`SLEEP_CYC))
        begin
          nxt_sleep   = pbsram_pkg::st_asleep;
          nxt_slp_cnt = `CNT_ZERO;
        end
      end
      pbsram_pkg::st_asleep:
      begin
        if (!sleep_f)
        begin
          nxt_sleep   = pbsram_pkg::st_leaving;
          nxt_slp_cnt = `CNT_ONE;
        end
      end
      pbsram_pkg::st_leaving:
      begin
        nxt_slp_cnt = slp_cnt_ff + `CNT_ONE;
        if (slp_cnt_ff >= 2'(`SLEEP_CYC))
        begin
          nxt_sleep   = pbsram_pkg::st_awake;
          nxt_slp_cnt = `CNT_ZERO;
        end
      end
      default:
      begin
        nxt_sleep   = pbsram_pkg::st_awake;
        nxt_slp_cnt = `CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sleep_ff   <= pbsram_pkg::st_awake;
      slp_cnt_ff <= `CNT_ZERO;
    end
    else
    begin
      sleep_ff   <= nxt_sleep;
      slp_cnt_ff <= nxt_slp_cnt;
    end
  end

  // accesses are only taken while fully awake; entry drops any in flight
  assign awake = (sleep_ff == pbsram_pkg::st_awake) && !sleep_f;

  // decode of the sampled control pins
  logic selected;
  logic proc_go;
  logic ctrl_go;
  logic wr_cond;
  logic deselect_now;
  assign selected = !ctl.chip_sel_a_n && ctl.chip_sel_b && !ctl.chip_sel_c_n;
  // processor strobe is ignored with chip select a high
  assign proc_go  = !ctl.proc_addr_strobe_n && !ctl.chip_sel_a_n;
  assign ctrl_go  = !ctl.ctrl_addr_strobe_n && !proc_go;
  assign wr_cond  = !ctl.global_write_n ||
                    (!ctl.lane_write_enable_n &&
                     (ctl.lane_select_n != '1));
  assign deselect_now = awake && (proc_go || ctrl_go) && !selected;

  // address register and burst counter
  logic [`ADDR_W-1:`LOW_ADDR_W] base_ff;
  logic [`ADDR_W-1:`LOW_ADDR_W] nxt_base;
  logic [`LOW_ADDR_W-1:0]       start_ff;
  logic [`LOW_ADDR_W-1:0]       nxt_start;
  logic [`LOW_ADDR_W-1:0]       cnt_ff;
  logic [`LOW_ADDR_W-1:0]       nxt_cnt;
  logic [`LOW_ADDR_W-1:0]       step_ff;
  logic [`LOW_ADDR_W-1:0]       nxt_step;
  logic                         active_ff;
  logic                         nxt_active;
  logic                         desel_ff;
  logic                         nxt_desel;
  logic                         rd_pend_ff;
  logic                         nxt_rd_pend;
  logic                         mask_ff;
  logic                         nxt_mask;
  logic [`ADDR_W-1:0]           rd_addr_ff;
  logic [`ADDR_W-1:0]           acc_addr;
  logic [`LOW_ADDR_W-1:0]       acc_lo;
  logic [`LOW_ADDR_W-1:0]       next_lo;
  logic                         wr_en;
  logic                         wr_all;

  always_comb
  begin
    if (order_interleaved)
    begin
      next_lo = start_ff ^ (step_ff + `LOW_ONE);
    end
    else
    begin
      next_lo = cnt_ff + `LOW_ONE;
    end
  end

  always_comb
  begin
    nxt_base    = base_ff;
    nxt_start   = start_ff;
    nxt_cnt     = cnt_ff;
    nxt_step    = step_ff;
    nxt_active  = active_ff;
    nxt_desel   = desel_ff;
    nxt_rd_pend = 1'b0;
    nxt_mask    = 1'b0;
    acc_lo      = cnt_ff;
    wr_en       = 1'b0;
    wr_all      = 1'b0;
    if (!awake)
    begin
      nxt_active = 1'b0;
      nxt_desel  = 1'b1;
    end
    else if (proc_go || ctrl_go)
    begin
      if (selected)
      begin
        nxt_base   = addr[`ADDR_W-1:`LOW_ADDR_W];
        nxt_start  = addr[`LOW_ADDR_W-1:0];
        nxt_cnt    = addr[`LOW_ADDR_W-1:0];
        nxt_step   = `LOW_ZERO;
        acc_lo     = addr[`LOW_ADDR_W-1:0];
        nxt_active = 1'b1;
        nxt_desel  = 1'b0;
        // processor strobe: write pins and advance ignored, always a read
        if (ctrl_go && wr_cond)
        begin
          wr_en  = 1'b1;
          wr_all = !ctl.global_write_n;
        end
        else
        begin
          nxt_rd_pend = 1'b1;
          nxt_mask    = desel_ff;
        end
      end
      else
      begin
        nxt_active = 1'b0;
        nxt_desel  = 1'b1;
      end
    end
    else if (active_ff)
    begin
      if (!ctl.burst_advance_n)
      begin
        nxt_step = step_ff + `LOW_ONE;
        nxt_cnt  = next_lo;
        acc_lo   = next_lo;
      end
      if (wr_cond)
      begin
        wr_en  = 1'b1;
        wr_all = !ctl.global_write_n;
      end
      else
      begin
        nxt_rd_pend = 1'b1;
      end
    end
  end

  assign acc_addr = {nxt_base, acc_lo};

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      base_ff    <= '0;
      start_ff   <= `LOW_ZERO;
      cnt_ff     <= `LOW_ZERO;
      step_ff    <= `LOW_ZERO;
      active_ff  <= 1'b0;
      desel_ff   <= 1'b1;
      rd_pend_ff <= 1'b0;
      mask_ff    <= 1'b0;
      rd_addr_ff <= '0;
    end
    else
    begin
      base_ff    <= nxt_base;
      start_ff   <= nxt_start;
      cnt_ff     <= nxt_cnt;
      step_ff    <= nxt_step;
      active_ff  <= nxt_active;
      desel_ff   <= nxt_desel;
      rd_pend_ff <= nxt_rd_pend;
      mask_ff    <= nxt_mask;
      rd_addr_ff <= acc_addr;
    end
  end

  // array, one nine-bit memory per lane; contents survive sleep and reset
  logic [`WORD_W-1:0] rd_word;

  genvar gl;
  generate
    for (gl = 0; gl < `NUM_LANES; gl++)
    begin : g_lane
      logic [`LANE_W-1:0] mem [0:`DEPTH-1];
      logic               lane_we;
      assign lane_we = wr_en &&
                       (wr_all || !ctl.lane_select_n[gl]);
      always_ff @(posedge sys_clk)
      begin
        if (lane_we)
        begin
          mem[acc_addr] <= {parity_pins_in[gl],
                            dq_in[gl*`BYTE_W +: `BYTE_W]};
        end
      end
      assign rd_word[gl*`LANE_W +: `LANE_W] = mem[rd_addr_ff];
    end
  endgenerate

  // output register: data one clock after the read address is taken
  logic [`DATA_W-1:0]    dq_out_ff;
  logic [`DATA_W-1:0]    nxt_dq_out;
  logic [`NUM_LANES-1:0] par_out_ff;
  logic [`NUM_LANES-1:0] nxt_par_out;
  logic                  drive_ff;
  logic                  nxt_drive;
  logic                  sleep_act_ff;

  always_comb
  begin
    nxt_dq_out  = dq_out_ff;
    nxt_par_out = par_out_ff;
    for (int i = 0; i < `NUM_LANES; i++)
    begin
      if (rd_pend_ff)
      begin
        nxt_dq_out[i*`BYTE_W +: `BYTE_W] =
          rd_word[i*`LANE_W +: `BYTE_W];
        nxt_par_out[i] = rd_word[i*`LANE_W + `BYTE_W];
      end
    end
    // a write or a deselect in this clock wins over a pending read
    nxt_drive = rd_pend_ff && !mask_ff && !oe_f_n && awake &&
                !wr_en && !deselect_now;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dq_out_ff    <= '0;
      par_out_ff   <= '0;
      drive_ff     <= 1'b0;
      sleep_act_ff <= 1'b0;
    end
    else
    begin
      dq_out_ff    <= nxt_dq_out;
      par_out_ff   <= nxt_par_out;
      drive_ff     <= nxt_drive;
      sleep_act_ff <= !awake;
    end
  end

  // enables are held low only while driving; oe changes land a clock late
  // because every pin output leaves a flip-flop
  logic [`DATA_W-1:0]    dq_oe_n_ff;
  logic [`NUM_LANES-1:0] par_oe_n_ff;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dq_oe_n_ff  <= '1;
      par_oe_n_ff <= '1;
    end
    else
    begin
      dq_oe_n_ff  <= {`DATA_W{!nxt_drive}};
      par_oe_n_ff <= {`NUM_LANES{!nxt_drive}};
    end
  end

  assign dq_out           = dq_out_ff;
  assign dq_oe_n          = dq_oe_n_ff;
  assign parity_pins_out  = par_out_ff;
  assign parity_pins_oe_n = par_oe_n_ff;
  assign sleep_active     = sleep_act_ff;

endmodule

/* pbsram_asserts.sv */
// Purpose: port checks for the pipelined burst sram access block
// Assumes: one clock domain, rst active high
// Notes:   oe figures leave room for the input synchroniser lag
`timescale 1ns/10ps
`include "pbsram_consts.svh"

module pbsram_asserts
(
  // clock and reset
  input wire logic                  sys_clk,
  input wire logic                  rst,
  // bus inputs
  input wire logic [`ADDR_W-1:0]    addr,
  input wire pbsram_pkg::bus_ctl_s  ctl,
  input wire logic                  out_en_n,
  input wire logic                  sleep_request,
  input wire logic                  burst_order_sel,
  input wire logic [`DATA_W-1:0]    dq_in,
  input wire logic [`NUM_LANES-1:0] parity_pins_in,
  // outputs
  input wire logic [`DATA_W-1:0]    dq_out,
  input wire logic [`DATA_W-1:0]    dq_oe_n,
  input wire logic [`NUM_LANES-1:0] parity_pins_out,
  input wire logic [`NUM_LANES-1:0] parity_pins_oe_n,
  input wire logic                  sleep_active
);
  logic cs_on;
  logic wr;
  logic go;
  logic strobe;
  logic desel;
  logic rd_on;
  logic ctl_wr;
  logic off;

  assign cs_on  = !ctl.chip_sel_a_n && ctl.chip_sel_b && !ctl.chip_sel_c_n;
  assign wr     = !ctl.global_write_n
               || (!ctl.lane_write_enable_n && !(&ctl.lane_select_n));
  assign strobe = (!ctl.proc_addr_strobe_n && !ctl.chip_sel_a_n)
               || !ctl.ctrl_addr_strobe_n;
  assign go     = !ctl.proc_addr_strobe_n && cs_on;
  assign desel  = strobe && !cs_on;
  assign rd_on  = !strobe && !wr;
  assign ctl_wr = !ctl.ctrl_addr_strobe_n && ctl.proc_addr_strobe_n
               && cs_on && wr;
  assign off    = &dq_oe_n && &parity_pins_oe_n;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_oe_low;
    (!out_en_n && !sleep_active) [*6];
  endsequence
  sequence s_two_reads;
    go ##1 rd_on [*2] ##1 go ##1 rd_on;
  endsequence
  sequence s_desel_read;
    desel ##1 go;
  endsequence

  a_oe_all_lanes: assert property (
    (dq_oe_n == '0 && parity_pins_oe_n == '0) || off)
    else $error("output enables disagree across lanes");
  a_ctrl_write_off: assert property (ctl_wr |=> off)
    else $error("drivers on after controller strobe write");
  a_cont_write_off: assert property (!strobe && wr |=> off)
    else $error("drivers on after continue write");
  a_oe_high_off: assert property (out_en_n [*8] |-> off)
    else $error("drivers on while output enable high");
  a_desel_off: assert property (desel |=> off)
    else $error("drivers on after deselect");
  a_first_read_off: assert property (s_desel_read |=> ##1 off)
    else $error("first read after deselect drove the pins");
  a_read_drives: assert property (
    s_oe_low ##1 s_two_reads |=> dq_oe_n == '0)
    else $error("read with output enable low left pins off");
  a_sleep_entry: assert property (sleep_request [*8] |-> sleep_active)
    else $error("sleep not entered");
  a_sleep_exit: assert property (
    (!sleep_request) [*8] |=> ##1 !sleep_active)
    else $error("sleep not left");
  a_sleep_off: assert property (sleep_active [*2] |-> off)
    else $error("drivers on while asleep");
endmodule

bind pipelined_burst_sram_access pbsram_asserts pbsram_asserts_i
(
  .sys_clk, .rst, .addr, .ctl, .out_en_n, .sleep_request,
  .burst_order_sel, .dq_in, .parity_pins_in, .dq_out, .dq_oe_n,
  .parity_pins_out, .parity_pins_oe_n, .sleep_active
);

/* pbsram_host.sv */
// Purpose: bus master model driving the burst sram pins
// Assumes: every pin changes just after a falling clock edge
// Notes:   released data lines flip each cycle so stale data never matches
`timescale 1ns/10ps
`include "pbsram_consts.svh"

module pbsram_host
(
  // clock
  input  wire logic                  sys_clk,
  // pins toward the sram
  output logic [`ADDR_W-1:0]         addr,
  output pbsram_pkg::bus_ctl_s       ctl,
  output logic                       out_en_n,
  output logic                       sleep_request,
  output logic                       burst_order_sel,
  output logic [`DATA_W-1:0]         dq_in,
  output logic [`NUM_LANES-1:0]      parity_pins_in,
  // pins read back
  input  wire logic [`DATA_W-1:0]    dq_out,
  input  wire logic [`NUM_LANES-1:0] parity_pins_out,
  input  wire logic                  oe_n
);
  // strobes, writes and lane selects high; chip selects active or idle
  localparam pbsram_pkg::bus_ctl_s ACT = 12'hffa;
  localparam pbsram_pkg::bus_ctl_s OFF = 12'hffd;
  logic [35:0] seen;
  logic        seen_off;

  initial
  begin
    addr = '0;
    ctl = OFF;
    out_en_n = 1'b1;
    sleep_request = 1'b0;
    burst_order_sel = 1'b1;
    {parity_pins_in, dq_in} = '0;
  end

  task automatic step(input pbsram_pkg::bus_ctl_s c, input logic [17:0] a,
                      input logic [35:0] d, input logic drv);
    @(negedge sys_clk);
    seen = {parity_pins_out, dq_out};
    seen_off = oe_n;
    ctl = c;
    addr = a;
    {parity_pins_in, dq_in} = drv ? d : ~{parity_pins_in, dq_in};
  endtask

  // idle keeps selects and strobes inactive
  task automatic idle(input int n);
    repeat (n) step(OFF, addr, '0, 1'b0);
  endtask

  // the synchroniser needs several clocks before a new level counts
  task automatic set_oe(input logic v);
    out_en_n = v;
    idle(8);
  endtask

  task automatic set_order(input logic v);
    burst_order_sel = v;
    idle(8);
  endtask

  task automatic deselect();
    pbsram_pkg::bus_ctl_s c = OFF;
    c.ctrl_addr_strobe_n = 1'b0;
    step(c, addr, '0, 1'b0);
  endtask

  task automatic wr_ctrl(input logic [17:0] a, input logic [3:0] sel_n,
                         input logic gw_n, input logic [35:0] d);
    pbsram_pkg::bus_ctl_s c = ACT;
    if (!out_en_n) set_oe(1'b1);
    c.ctrl_addr_strobe_n = 1'b0;
    c.global_write_n = gw_n;
    c.lane_write_enable_n = 1'b0;
    c.lane_select_n = sel_n;
    step(c, a, d, 1'b1);
  endtask

  // first cycle carries inverted data with write asserted: it must be ignored
  task automatic wr_proc(input logic [17:0] a, input logic [35:0] d,
                         input logic adv_n);
    pbsram_pkg::bus_ctl_s c = ACT;
    if (!out_en_n) set_oe(1'b1);
    c.proc_addr_strobe_n = 1'b0;
    c.global_write_n = 1'b0;
    step(c, a, ~d, 1'b1);
    c = ACT;
    c.global_write_n = 1'b0;
    c.burst_advance_n = adv_n;
    step(c, a, d, 1'b1);
  endtask

  task automatic both(input logic [17:0] a, input logic [35:0] d);
    pbsram_pkg::bus_ctl_s c = ACT;
    c.proc_addr_strobe_n = 1'b0;
    c.ctrl_addr_strobe_n = 1'b0;
    c.global_write_n = 1'b0;
    step(c, a, d, 1'b1);
  endtask

  task automatic rd_burst(input logic [17:0] a, input int n,
                          output logic [35:0] q [4], output logic off0);
    pbsram_pkg::bus_ctl_s c = ACT;
    c.proc_addr_strobe_n = 1'b0;
    step(c, a, '0, 1'b0);
    for (int i = 0; i <= n; i++)
    begin
      c = ACT;
      c.burst_advance_n = (i >= n - 1);
      step(c, a, '0, 1'b0);
      if (i == 1) off0 = seen_off;
      if (i > 0) q[i-1] = seen;
    end
  endtask

  // deselect first, then hold everything idle through recovery
  task automatic sleep_on(input int n);
    deselect();
    sleep_request = 1'b1;
    idle(n);
  endtask

  task automatic sleep_off(input int n);
    sleep_request = 1'b0;
    idle(n);
  endtask
endmodule

/* pipelined_burst_sram_access_tb_top.sv */
// Purpose: self-checking bench for the pipelined burst sram access block
// Assumes: the host model drives every pin except clock and reset; the bench keeps expected words
// Notes:   words are {parity, data}; only addresses 10h to 13h are used
`timescale 1ns/10ps
`include "pbsram_consts.svh"

module pipelined_burst_sram_access_tb_top;
  logic                  sys_clk;
  logic                  rst;
  logic [`ADDR_W-1:0]    addr;
  pbsram_pkg::bus_ctl_s  ctl;
  logic                  oe_in_n;
  logic                  sleep_req;
  logic                  order;
  logic [`DATA_W-1:0]    dq_in;
  logic [`DATA_W-1:0]    dq_out;
  logic [`DATA_W-1:0]    dq_oe_n;
  logic [`NUM_LANES-1:0] par_in;
  logic [`NUM_LANES-1:0] par_out;
  logic [`NUM_LANES-1:0] par_oe_n;
  logic                  sleep_active;
  logic [35:0]           mem [4];
  logic [35:0]           q [4];
  logic                  off0;
  int                    n_fail;
  int                    check_count;

  pipelined_burst_sram_access pipelined_burst_sram_access_i
  (
    .sys_clk(sys_clk), .rst(rst), .addr(addr), .ctl(ctl),
    .out_en_n(oe_in_n), .sleep_request(sleep_req), .burst_order_sel(order),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .parity_pins_in(par_in), .parity_pins_out(par_out),
    .parity_pins_oe_n(par_oe_n), .sleep_active(sleep_active)
  );

  pbsram_host pbsram_host_i
  (
    .sys_clk(sys_clk), .addr(addr), .ctl(ctl), .out_en_n(oe_in_n),
    .sleep_request(sleep_req), .burst_order_sel(order), .dq_in(dq_in),
    .parity_pins_in(par_in), .dq_out(dq_out), .parity_pins_out(par_out),
    .oe_n(dq_oe_n[0])
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [35:0] e,
                     input logic [35:0] g);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // a lane is eight data bits plus its parity bit
  function automatic logic [35:0] lanes(input logic [3:0] sel_n);
    lanes = '0;
    for (int i = 0; i < 4; i++)
      if (!sel_n[i])
        lanes |= (36'h0_0000_00ff << (8 * i)) | (36'h1_0000_0000 << i);
  endfunction

  task automatic wr(input logic [1:0] i, input logic [3:0] sel_n,
                    input logic gw_n, input logic [35:0] d);
    logic [35:0] m;
    m = gw_n ? lanes(sel_n) : '1;
    pbsram_host_i.wr_ctrl({16'h0004, i}, sel_n, gw_n, d);
    mem[i] = (mem[i] & ~m) | (d & m);
  endtask

  task automatic rdchk(input logic [1:0] s, input int n);
    pbsram_host_i.rd_burst({16'h0004, s}, n, q, off0);
    for (int j = 0; j < n; j++)
      chk("burst word", mem[order ? s ^ 2'(j) : s + 2'(j)], q[j]);
  endtask

  initial
  begin
    n_fail = 0;
    check_count = 0;
    rst = 1'b1;
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    for (int i = 0; i < 4; i++)
      wr(2'(i), 4'hf, 1'b0, 36'h9_8765_4321 ^ (36'(i) * 36'h3_0303_0303));
    pbsram_host_i.set_oe(1'b0);
    pbsram_host_i.deselect();
    rdchk(2'h1, 4);
    chk("first read oe", 36'h1, 36'(off0));
    rdchk(2'h2, 1);
    chk("read oe", 36'h0, 36'(off0));
    rdchk(2'h3, 1);
    pbsram_host_i.set_order(1'b0);
    rdchk(2'h2, 4);
    wr(2'h0, 4'ha, 1'b1, 36'h6_c3c3_c3c3);
    wr(2'h1, 4'hf, 1'b1, 36'h5_1111_1111);
    rdchk(2'h0, 1);
    chk("oe high read", 36'h1, 36'(off0));
    pbsram_host_i.wr_proc(18'h13, 36'ha_0b0c_0d0e, 1'b1);
    mem[3] = 36'ha_0b0c_0d0e;
    pbsram_host_i.wr_proc(18'h10, 36'h3_7777_8888, 1'b0);
    mem[1] = 36'h3_7777_8888;
    pbsram_host_i.both(18'h12, 36'h0_dead_0bad);
    pbsram_host_i.set_oe(1'b0);
    rdchk(2'h0, 4);
    pbsram_host_i.sleep_on(12);
    chk("sleep status", 36'h1, 36'(sleep_active));
    chk("sleep oe", 36'hf_ffff_ffff, {par_oe_n, dq_oe_n});
    pbsram_host_i.sleep_off(12);
    chk("wake status", 36'h0, 36'(sleep_active));
    rdchk(2'h0, 4);
    report_and_stop;
  end

  // the sequence needs about 120 clocks; this allows ample margin
  initial
  begin
    #(2000 * 100);
    n_fail++;
    report_and_stop;
  end
endmodule
